// ---- src/csdf_test_path.sv ----
// What this block does
// - multiply by repeated shift and add into the running sum, no multiplier
// - FIR section with last index n has n plus one taps, weighted and summed
// - each signed digit is four bits: sign on top, three-bit shift below
// - sign one flips the running sign, sign zero keeps it; each shifted term is added or subtracted by that sign
// - shift code is plain unsigned binary, zero to seven shifts
// - first shift from binary point, later shifts relative to previous digit
// - group one is the most significant digit; second index picks coefficient
// - digits per coefficient: four for most filters, three for B FIR, two for Z post; shared engine built with four groups
// - transmit gain uses one plus decoded value as its coefficient
// - transmit cutoff floats pcm out and strobe, beats both loopbacks
// - receive cutoff zeroes signal before receive low-pass, blocking tone but not slot loopback
// - high-pass bypass skips every transmit high-pass and notch stage
// - extra receive loss inserts a fixed 6.02 dB loss
// - transmit data readable by a dedicated processor read command
// - armed interrupt raised on each new transmit sample, cleared on read
// - slot loopback puts received slot data into transmit slot
// - full digital loopback drops analog out, feeds it back, stops scaling path
// - writing code 10000 to impedance scaling enters full digital loopback
// - receive tone injects 1 kHz digital milliwatt replacing slot data
// - read returns two bytes: transmit upper byte, then reserved
`timescale 1ns/1ps
module csdf_test_path import csdf_pkg::*; #(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES,
  parameter int NTAPS = FIR_LAST_IDX + 1
) (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire csdf_ctl_t CTRL,
  input wire logic [COEF_W-1:0] TX_GAIN_COEF,
  input wire logic [COEF_W-1:0] RX_GAIN_COEF,
  input wire logic [NTAPS-1:0][COEF_W-1:0] RX_FIR_COEF,
  input wire logic [DW-1:0] ANALOG_IN,
  input wire logic [DW-1:0] PCM_RX_IN,
  input wire logic IMP_SCALE_WR,
  input wire logic [4:0] IMP_SCALE_DATA,
  input wire logic RD_REQ,
  input wire logic [7:0] RD_CMD,
  output logic [DW-1:0] PCM_TX_OUT,
  output logic PCM_TX_OE,
  output logic TX_SLOT_STROBE_N,
  output logic TX_SLOT_STROBE_OE,
  output logic [DW-1:0] ANALOG_OUT,
  output logic ANALOG_OUT_EN,
  output logic IMP_SCALE_EN,
  output logic TX_IRQ,
  output logic RD_VALID,
  output logic [7:0] RD_DATA
);

  localparam int CW = $clog2(SAMPLE_CYCLES_P);
  localparam int TW = $clog2(NTAPS);

  typedef struct packed {
    csdf_st_t st;
    logic [CW-1:0] div;
    csdf_ctl_t ctl;
    logic code_fdl;
    logic [DW-1:0] rx_s1;
    logic [DW-1:0] rx_s2;
    logic [DW-1:0] rx_slot;
    logic [DW-1:0] tx_in;
    logic [DW-1:0] hp_x1;
    logic [DW-1:0] hp_y;
    logic [2:0] tone_idx;
    logic [NTAPS-1:0][DW-1:0] dline;
    logic [TW-1:0] tap;
    logic [AW-1:0] fir_acc;
    logic [DW-1:0] pcm_tx_out;
    logic pcm_tx_oe;
    logic strobe_n;
    logic strobe_oe;
    logic [DW-1:0] analog_out;
    logic analog_out_en;
    logic imp_en;
    logic irq;
    logic [7:0] tx_byte;
    logic rd_valid;
    logic [7:0] rd_data;
    logic rd_second;
  } csdf_top_state_t;

  csdf_top_state_t r;
  csdf_top_state_t n;

  logic tick;
  logic mul_start;
  logic mul_done;
  logic [DW-1:0] mul_sample;
  logic [COEF_W-1:0] mul_coef;
  logic mul_plus_one;
  logic [AW-1:0] mul_prod;
  logic irq_set;
  logic irq_clr;

  ////////////////////////////////////////////////////////////////////////////
  // shared shift-and-add engine, time-multiplexed over transmit gain, receive FIR and receive gain

  assign tick = (r.div == CW'(SAMPLE_CYCLES_P - 1));
  assign mul_start = (r.st == ST_TX_GO) || (r.st == ST_FIR_GO) || (r.st == ST_GAIN_GO);
  assign mul_plus_one = (r.st == ST_TX_GO);
  assign mul_sample = (r.st == ST_TX_GO) ? r.hp_y :
                      (r.st == ST_FIR_GO) ? r.dline[r.tap] : csdf_sat(r.fir_acc);
  assign mul_coef = (r.st == ST_TX_GO) ? TX_GAIN_COEF :
                    (r.st == ST_FIR_GO) ? RX_FIR_COEF[r.tap] : RX_GAIN_COEF;

  csdf_csd_mul #(
    .GROUPS(GROUPS_STD)
  ) u_mul (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start(mul_start),
    .sample(mul_sample),
    .coef(mul_coef),
    .plus_one(mul_plus_one),
    .busy(),
    .done(mul_done),
    .product(mul_prod)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    csdf_ctl_t c;
    logic [DW-1:0] src;
    logic [DW-1:0] w;
    logic [AW-1:0] hp;
    c = CTRL;
    src = '0;
    w = '0;
    hp = '0;
    n = r;
    irq_set = 1'b0;
    irq_clr = 1'b0;
    n.rd_valid = 1'b0;
    n.strobe_n = 1'b1;
    n.rx_s1 = PCM_RX_IN;
    n.rx_s2 = r.rx_s1;
    n.div = tick ? '0 : r.div + CW'(1);
    if (IMP_SCALE_WR) n.code_fdl = (IMP_SCALE_DATA == FDL_CODE);
    if (r.rd_second) begin
      n.rd_valid = 1'b1;
      n.rd_data = RSVD_BYTE;
      n.rd_second = 1'b0;
    end else if (RD_REQ && RD_CMD == CMD_READ_TX) begin
      n.rd_valid = 1'b1;
      n.rd_data = r.tx_byte;
      n.rd_second = 1'b1;
      irq_clr = 1'b1;
    end
    unique case (r.st)
      ST_IDLE: begin
        if (tick) begin
          // bits are taken only here so a sample never sees a half-applied mode
          c.full_digital_loopback = CTRL.full_digital_loopback | r.code_fdl;
          n.ctl = c;
          n.pcm_tx_oe = !c.tx_path_cutoff;
          n.strobe_oe = !c.tx_path_cutoff;
          n.analog_out_en = !c.full_digital_loopback;
          n.imp_en = !c.full_digital_loopback;
          n.tx_in = c.full_digital_loopback ? r.analog_out : ANALOG_IN;
          n.rx_slot = r.rx_s2;
          src = c.rx_test_tone ? csdf_tone(r.tone_idx) : r.rx_s2;
          n.tone_idx = c.rx_test_tone ? r.tone_idx + 3'h1 : 3'h0;
          if (c.rx_extra_loss) src = {src[DW-1], src[DW-1:1]};
          if (c.rx_path_cutoff) src = '0;
          n.dline = {r.dline[NTAPS-2:0], src};
          n.st = ST_TX_HP;
        end
      end
      ST_TX_HP: begin
        // single dc-blocking stage stands in for the high-pass and notch chain
        hp = csdf_ext(r.tx_in) - csdf_ext(r.hp_x1) + csdf_ext(r.hp_y)
             - AW'($signed(csdf_ext(r.hp_y)) >>> HP_SHIFT);
        n.hp_y = r.ctl.tx_highpass_bypass ? r.tx_in : csdf_sat(hp);
        n.hp_x1 = r.tx_in;
        n.st = ST_TX_GO;
      end
      ST_TX_GO: begin
        n.st = ST_TX_WAIT;
      end
      ST_TX_WAIT: begin
        if (mul_done) begin
          w = r.ctl.slot_loopback ? r.rx_slot : csdf_sat(mul_prod);
          if (!r.ctl.tx_path_cutoff) begin
            n.pcm_tx_out = w;
            n.strobe_n = 1'b0;
            n.tx_byte = w[DW-1 -: 8];
            irq_set = r.ctl.tx_data_irq_arm;
          end
          n.tap = '0;
          n.fir_acc = '0;
          n.st = ST_FIR_GO;
        end
      end
      ST_FIR_GO: begin
        n.st = ST_FIR_WAIT;
      end
      ST_FIR_WAIT: begin
        if (mul_done) begin
          n.fir_acc = r.fir_acc + mul_prod;
          if (r.tap == TW'(NTAPS - 1)) begin
            n.st = ST_GAIN_GO;
          end else begin
            n.tap = r.tap + TW'(1);
            n.st = ST_FIR_GO;
          end
        end
      end
      ST_GAIN_GO: begin
        n.st = ST_GAIN_WAIT;
      end
      ST_GAIN_WAIT: begin
        if (mul_done) begin
          n.analog_out = csdf_sat(mul_prod);
          n.st = ST_IDLE;
        end
      end
    endcase
    // a new sample beats a read landing in the same cycle
    if (irq_set) n.irq = 1'b1;
    else if (irq_clr) n.irq = 1'b0;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      r <= '0;
      r.strobe_n <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign PCM_TX_OUT = r.pcm_tx_out;
  assign PCM_TX_OE = r.pcm_tx_oe;
  assign TX_SLOT_STROBE_N = r.strobe_n;
  assign TX_SLOT_STROBE_OE = r.strobe_oe;
  assign ANALOG_OUT = r.analog_out;
  assign ANALOG_OUT_EN = r.analog_out_en;
  assign IMP_SCALE_EN = r.imp_en;
  assign TX_IRQ = r.irq;
  assign RD_VALID = r.rd_valid;
  assign RD_DATA = r.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_cutoff_floats: assert property (
    r.ctl.tx_path_cutoff |-> !PCM_TX_OE && !TX_SLOT_STROBE_OE && TX_SLOT_STROBE_N)
    else $error("pcm transmit driven during cutoff");

  a_loop_overwrite: assert property (
    (r.st == ST_TX_WAIT && mul_done && r.ctl.slot_loopback && !r.ctl.tx_path_cutoff)
    |=> PCM_TX_OUT == $past(r.rx_slot) && !TX_SLOT_STROBE_N)
    else $error("slot loopback data not sent");

  a_rx_cutoff_zero: assert property (
    (r.st == ST_TX_HP && r.ctl.rx_path_cutoff) |-> r.dline[0] == '0)
    else $error("receive signal not zero under cutoff");

  a_hp_bypass: assert property (
    (r.st == ST_TX_HP && r.ctl.tx_highpass_bypass) |=> r.hp_y == $past(r.tx_in))
    else $error("high-pass not bypassed");

  a_rx_loss: assert property (
    (r.st == ST_IDLE && tick && CTRL.rx_extra_loss && !CTRL.rx_path_cutoff
     && !CTRL.rx_test_tone)
    |=> $signed(r.dline[0]) == ($signed($past(r.rx_s2)) >>> 1))
    else $error("receive loss not applied");

  a_irq_raise: assert property (
    (r.st == ST_TX_WAIT && mul_done && r.ctl.tx_data_irq_arm && !r.ctl.tx_path_cutoff)
    |=> TX_IRQ)
    else $error("interrupt not raised on new data");

  a_irq_clear: assert property (
    (irq_clr && !irq_set) |=> !TX_IRQ)
    else $error("interrupt not cleared by read");

  a_read_two_bytes: assert property (
    (RD_REQ && RD_CMD == CMD_READ_TX && !r.rd_second)
    |=> (RD_VALID && RD_DATA == $past(r.tx_byte)) ##1 (RD_VALID && RD_DATA == RSVD_BYTE))
    else $error("read answer not two bytes");

  a_fdl_outputs_off: assert property (
    r.ctl.full_digital_loopback |-> !ANALOG_OUT_EN && !IMP_SCALE_EN)
    else $error("analog out on in digital loopback");

  a_fdl_code: assert property (
    (IMP_SCALE_WR && IMP_SCALE_DATA == FDL_CODE) |=> r.code_fdl)
    else $error("scaling code did not arm loopback");

  a_tone_inject: assert property (
    (r.st == ST_IDLE && tick && CTRL.rx_test_tone && !CTRL.rx_extra_loss
     && !CTRL.rx_path_cutoff) |=> r.dline[0] == csdf_tone($past(r.tone_idx)))
    else $error("tone not injected");

  a_ctl_hold: assert property (
    (r.st != ST_IDLE) |=> $stable(r.ctl))
    else $error("mode changed inside a sample");

  a_strobe_pulse: assert property (
    !TX_SLOT_STROBE_N |=> TX_SLOT_STROBE_N)
    else $error("slot strobe longer than one cycle");

  a_cutoff_no_slot: assert property (
    (r.st == ST_TX_WAIT && r.ctl.tx_path_cutoff) |=> TX_SLOT_STROBE_N && $stable(PCM_TX_OUT))
    else $error("transmit slot sent during cutoff");

  a_irq_set_wins: assert property (
    irq_set |=> TX_IRQ)
    else $error("new sample did not raise interrupt");

  a_bad_cmd_quiet: assert property (
    (RD_REQ && RD_CMD != CMD_READ_TX && !r.rd_second) |=> !RD_VALID)
    else $error("unknown command answered");

  a_second_byte: assert property (
    r.rd_second |=> RD_VALID && RD_DATA == RSVD_BYTE)
    else $error("reserved byte missing");

  a_fdl_feeds_in: assert property (
    (r.st == ST_IDLE && tick && (CTRL.full_digital_loopback || r.code_fdl))
    |=> r.tx_in == $past(r.analog_out))
    else $error("loopback input not taken from output");

  a_tone_restart: assert property (
    (r.st == ST_IDLE && tick && !CTRL.rx_test_tone) |=> r.tone_idx == 3'h0)
    else $error("tone phase not restarted");

  c_cutoff: cover property (r.st == ST_TX_WAIT && mul_done && r.ctl.tx_path_cutoff);
  c_loopback: cover property (!TX_SLOT_STROBE_N && r.ctl.slot_loopback);
  c_read: cover property (RD_VALID ##1 RD_VALID);
  c_tone_fdl: cover property (r.ctl.rx_test_tone && r.ctl.full_digital_loopback);
  c_fdl_code: cover property (r.code_fdl && r.st == ST_TX_HP);

endmodule

// ---- pkg/csdf_pkg.sv ----
package csdf_pkg;

  localparam int DW = 16;
  localparam int AW = 20;
  localparam int GRP_W = 4;
  localparam int SHIFT_W = 3;
  localparam int SIGN_POS = 3;
  localparam int GROUPS_STD = 4;
  localparam int GROUPS_B_FIR = 3;
  localparam int GROUPS_Z_POST = 2;
  localparam int COEF_W = GRP_W * GROUPS_STD;
  localparam int FIR_LAST_IDX = 4;

  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_PERIOD_US = 125;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;

  localparam logic [7:0] CMD_READ_TX = 8'hCD;
  localparam logic [7:0] RSVD_BYTE = 8'h00;
  localparam logic [4:0] FDL_CODE = 5'h10;
  localparam int HP_SHIFT = 6;
  localparam int TONE_STEPS = 8;

  typedef struct packed {
    logic tx_path_cutoff;
    logic rx_path_cutoff;
    logic tx_highpass_bypass;
    logic rx_extra_loss;
    logic tx_data_irq_arm;
    logic slot_loopback;
    logic full_digital_loopback;
    logic rx_test_tone;
  } csdf_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_TX_HP, ST_TX_GO, ST_TX_WAIT, ST_FIR_GO, ST_FIR_WAIT, ST_GAIN_GO, ST_GAIN_WAIT
  } csdf_st_t;

  // eight points per cycle at the sample rate give 1 kHz; amplitude arbitrary
  function automatic logic [DW-1:0] csdf_tone(input logic [2:0] idx);
    unique case (idx)
      3'h0: return 16'h0000;
      3'h1: return 16'h2D41;
      3'h2: return 16'h4000;
      3'h3: return 16'h2D41;
      3'h4: return 16'h0000;
      3'h5: return 16'hD2BF;
      3'h6: return 16'hC000;
      default: return 16'hD2BF;
    endcase
  endfunction

  function automatic logic [AW-1:0] csdf_ext(input logic [DW-1:0] x);
    return {{(AW-DW){x[DW-1]}}, x};
  endfunction

  function automatic logic [DW-1:0] csdf_sat(input logic [AW-1:0] v);
    if (!v[AW-1] && (|v[AW-2:DW-1])) return {1'b0, {(DW-1){1'b1}}};
    else if (v[AW-1] && !(&v[AW-2:DW-1])) return {1'b1, {(DW-1){1'b0}}};
    else return v[DW-1:0];
  endfunction

endpackage

// ---- src/csdf_csd_mul.sv ----
`timescale 1ns/1ps
module csdf_csd_mul import csdf_pkg::*; #(
  parameter int GROUPS = GROUPS_STD
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [DW-1:0] sample,
  input wire logic [GRP_W*GROUPS-1:0] coef,
  input wire logic plus_one,
  output logic busy,
  output logic done,
  output logic [AW-1:0] product
);

  localparam int IW = $clog2(GROUPS + 1);
  localparam int SW = $clog2(GROUPS * 7 + 1);
  localparam int CFW = GRP_W * GROUPS;

  typedef struct packed {
    logic busy;
    logic done;
    logic [IW-1:0] idx;
    logic [SW-1:0] shift;
    logic sign;
    logic [AW-1:0] x;
    logic [AW-1:0] acc;
    logic [CFW-1:0] coef;
  } csdf_mul_state_t;

  csdf_mul_state_t r;
  csdf_mul_state_t n;

  always_comb begin
    logic [GRP_W-1:0] grp;
    logic [SW-1:0] sh;
    logic sg;
    logic [AW-1:0] term;
    grp = r.coef[CFW-1 -: GRP_W];
    sh = r.shift + SW'(grp[SHIFT_W-1:0]);
    sg = r.sign ^ grp[SIGN_POS];
    term = AW'($signed(r.x) >>> sh);
    n = r;
    n.done = 1'b0;
    if (start && !r.busy) begin
      n.busy = 1'b1;
      n.idx = '0;
      n.shift = '0;
      n.sign = 1'b0;
      n.x = csdf_ext(sample);
      n.acc = plus_one ? csdf_ext(sample) : '0;
      n.coef = coef;
    end else if (r.busy) begin
      // one shifted add per group instead of a multiplier array
      n.acc = sg ? r.acc - term : r.acc + term;
      n.shift = sh;
      n.sign = sg;
      n.coef = {r.coef[CFW-GRP_W-1:0], {GRP_W{1'b0}}};
      n.idx = r.idx + IW'(1);
      if (r.idx == IW'(GROUPS - 1)) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) r <= '0;
    else r <= n;
  end

  assign busy = r.busy;
  assign done = r.done;
  assign product = r.acc;

endmodule

// ---- tb/csdf_proc_model.sv ----
`timescale 1ns/1ps
module csdf_proc_model import csdf_pkg::*; (
  input wire logic clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  output csdf_ctl_t ctrl,
  output logic [COEF_W-1:0] gx,
  output logic [COEF_W-1:0] gr,
  output logic [4:0][COEF_W-1:0] fir,
  output logic rd_req,
  output logic [7:0] rd_cmd,
  output logic imp_wr,
  output logic [4:0] imp_data
);
  initial begin
    ctrl = '0;
    gx = '0;
    gr = '0;
    fir = '0;
    rd_req = 1'b0;
    rd_cmd = '0;
    imp_wr = 1'b0;
    imp_data = '0;
  end
  ////////////////////////////////////////
  // called at a rising edge; all settings move together
  task automatic prog(input csdf_ctl_t c, input logic [15:0] t, input logic [15:0] r,
                      input logic [4:0][15:0] f);
    ctrl <= c;
    gx <= t;
    gr <= r;
    fir <= f;
  endtask
  task automatic wr_imp(input logic [4:0] code);
    @(posedge clk);
    imp_wr <= 1'b1;
    imp_data <= code;
    @(posedge clk);
    imp_wr <= 1'b0;
  endtask
  // missing second byte shows as unknown, so a short reply cannot pass
  task automatic read_tx(input logic [7:0] cmd, output logic [7:0] b1,
                         output logic [7:0] b2, output logic ok);
    int n;
    @(posedge clk);
    rd_req <= 1'b1;
    rd_cmd <= cmd;
    @(posedge clk);
    rd_req <= 1'b0;
    #1 n = 0;
    while (rd_valid !== 1'b1 && n < 3) begin
      @(posedge clk);
      #1 n++;
    end
    ok = (rd_valid === 1'b1);
    b1 = rd_data;
    @(posedge clk);
    #1 b2 = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench import csdf_pkg::*;;
  localparam int SP = 64;
  localparam logic [15:0] ZERO = 16'h08F8;
  localparam logic [15:0] ONE = 16'h1078;
  localparam int TONE[8] = '{0, 11585, 16384, 11585, 0, -11585, -16384, -11585};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [DW-1:0] ain = '0;
  logic [DW-1:0] prx = '0;
  csdf_ctl_t ctrl;
  csdf_ctl_t c;
  logic [COEF_W-1:0] gx, gr, gxv, grv;
  logic [4:0][COEF_W-1:0] fir, firv;
  logic imp_wr, rd_req, ptx_oe, stb_n, stb_oe, aout_en, imp_en, irq, rd_valid, ok;
  logic [4:0] imp_data;
  logic [7:0] rd_cmd, rd_data, b1, b2;
  logic [DW-1:0] ptx, aout;
  logic [15:0] tq[$];
  int failures = 0, comparisons = 0, cyc = 0, strobes = 0, aexp = 0, texp = 0, hit, m;
  int rh[5];
  logic fdl_armed = 1'b0;
  csdf_test_path #(.SAMPLE_CYCLES_P(SP)) u_csdf_test_path (.CLOCK(clk), .RST_N(rst_n),
    .CTRL(ctrl), .TX_GAIN_COEF(gx), .RX_GAIN_COEF(gr), .RX_FIR_COEF(fir), .ANALOG_IN(ain),
    .PCM_RX_IN(prx), .IMP_SCALE_WR(imp_wr), .IMP_SCALE_DATA(imp_data), .RD_REQ(rd_req),
    .RD_CMD(rd_cmd), .PCM_TX_OUT(ptx), .PCM_TX_OE(ptx_oe), .TX_SLOT_STROBE_N(stb_n),
    .TX_SLOT_STROBE_OE(stb_oe), .ANALOG_OUT(aout), .ANALOG_OUT_EN(aout_en),
    .IMP_SCALE_EN(imp_en), .TX_IRQ(irq), .RD_VALID(rd_valid), .RD_DATA(rd_data));
  csdf_proc_model u_csdf_proc_model (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
    .ctrl(ctrl), .gx(gx), .gr(gr), .fir(fir), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .imp_wr(imp_wr), .imp_data(imp_data));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // counted on the falling edge so the phase is settled at every rising edge
  always @(negedge clk) if (rst_n) cyc <= cyc + 1;
  always @(posedge clk) begin
    if (rst_n && stb_n === 1'b0) strobes <= strobes + 1;
    if (cyc == 4000) begin
      failures++;
      close_out();
    end
  end
  ////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // floor per term: same result as shifting the multiplicand step by step
  function automatic int csd(input logic [15:0] cf, input int x);
    int s, sh, acc;
    s = 1;
    sh = 0;
    acc = 0;
    for (int g = 3; g >= 0; g--) begin
      if (cf[4*g+3]) s = -s;
      sh += int'(cf[4*g +: 3]);
      acc += s * (x >>> sh);
    end
    return acc;
  endfunction
  // small shifts keep every product exact and below full scale
  function automatic logic [15:0] rcoef();
    logic [15:0] v;
    v = 16'($urandom);
    v[14:12] = 3'(2 + $urandom_range(1));
    v[10:9] = 2'b00;
    v[6:5] = 2'b00;
    v[2:1] = 2'b00;
    return v;
  endfunction
  function automatic int rs();
    return (int'($urandom_range(15)) - 8) * 512;
  endfunction
  task automatic at_phase(input int p);
    do @(posedge clk); while (cyc % SP != p);
  endtask
  task automatic step(input csdf_ctl_t k, input int ax, input int rv);
    int r, f, tin, s0;
    logic lb;
    @(posedge clk);
    u_csdf_proc_model.prog(k, gxv, grv, firv);
    ain <= 16'(ax);
    prx <= 16'(rv);
    s0 = strobes;
    lb = k.full_digital_loopback || fdl_armed;
    tin = lb ? aexp : ax;
    r = k.rx_test_tone ? 0 : (k.rx_extra_loss ? rv >>> 1 : rv);
    if (k.rx_path_cutoff) r = 0;
    for (int i = 4; i > 0; i--) rh[i] = rh[i-1];
    rh[0] = r;
    f = 0;
    for (int i = 0; i < 5; i++) f += csd(firv[i], rh[i]);
    aexp = csd(grv, f);
    if (!k.tx_path_cutoff) texp = k.slot_loopback ? rv : tin + csd(gxv, tin);
    at_phase(50);
    chk("pcm_tx_out", 16'(texp), ptx);
    chk("pcm_tx_oe", 16'(!k.tx_path_cutoff), 16'(ptx_oe));
    chk("strobe_oe", 16'(!k.tx_path_cutoff), 16'(stb_oe));
    chk("strobe_count", 16'(!k.tx_path_cutoff), 16'(strobes - s0));
    chk("analog_out_en", 16'(!lb), 16'(aout_en));
    chk("imp_scale_en", 16'(!lb), 16'(imp_en));
    chk("tx_irq", 16'(k.tx_data_irq_arm && !k.tx_path_cutoff), 16'(irq));
    if (k.rx_test_tone && !k.rx_path_cutoff) tq.push_back(aout);
    else chk("analog_out", 16'(aexp), aout);
    if (!k.tx_path_cutoff) begin
      u_csdf_proc_model.read_tx(CMD_READ_TX, b1, b2, ok);
      chk("read_valid", 16'h0001, 16'(ok));
      chk("read_byte1", {8'h00, 8'(texp >>> 8)}, {8'h00, b1});
      chk("read_byte2", 16'h0000, {8'h00, b2});
      chk("tx_irq_read", 16'h0000, 16'(irq));
    end
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h5f7f));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset_oe", 16'h0000, 16'({ptx_oe, aout_en, irq, rd_valid}));
    chk("reset_strobe", 16'h0001, 16'(stb_n));
    at_phase(50);
    grv = ONE;
    repeat (14) begin
      gxv = rcoef();
      for (int i = 0; i < 5; i++) firv[i] = rcoef();
      c = csdf_ctl_t'(8'($urandom));
      c.tx_highpass_bypass = 1'b1;
      c.rx_test_tone = 1'b0;
      c.full_digital_loopback = 1'b0;
      step(c, rs(), rs());
    end
    $display("test random_paths done");
    firv = {ZERO, ZERO, ZERO, ZERO, ONE};
    c = '0;
    c.tx_highpass_bypass = 1'b1;
    c.rx_test_tone = 1'b1;
    repeat (8) step(c, 0, 4096);
    hit = 0;
    for (int p = 0; p < 8; p++) begin
      m = 1;
      for (int i = 0; i < 8; i++) if (tq[i] !== 16'(csd(ONE, csd(ONE, TONE[(p+i)%8])))) m = 0;
      hit |= m;
    end
    chk("tone_sequence", 16'h0001, 16'(hit));
    c.rx_path_cutoff = 1'b1;
    step(c, 0, 4096);
    $display("test tone_and_cutoff done");
    c = '0;
    c.tx_highpass_bypass = 1'b1;
    c.tx_path_cutoff = 1'b1;
    c.slot_loopback = 1'b1;
    c.full_digital_loopback = 1'b1;
    c.tx_data_irq_arm = 1'b1;
    step(c, rs(), rs());
    $display("test tx_cutoff done");
    gxv = ZERO;
    c = '0;
    c.tx_highpass_bypass = 1'b1;
    c.full_digital_loopback = 1'b1;
    step(c, rs(), 2048);
    step(c, rs(), -1536);
    c.full_digital_loopback = 1'b0;
    u_csdf_proc_model.wr_imp(5'h10);
    fdl_armed = 1'b1;
    step(c, rs(), 1024);
    step(c, rs(), 512);
    u_csdf_proc_model.wr_imp(5'h03);
    fdl_armed = 1'b0;
    step(c, rs(), 512);
    $display("test loopback done");
    u_csdf_proc_model.read_tx(8'h3C, b1, b2, ok);
    chk("bad_cmd_valid", 16'h0000, 16'(ok));
    $display("test bad_command done");
    close_out();
  end
endmodule
